// File: core/nested_step_sequencer.sv
/*
 * nested step sequencer: walks eight sixteen-step sequences with nested
 * calls and sends segment numbers and end-segment commands to motor control.
 * assumes an APB master on clk_sys and a motor control that pulses segDone
 * on clk_sys when the current segment has been processed.
 */
`timescale 1ns/1ps
module nested_step_sequencer
  import seq_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // motor control
  input  wire logic              segDone,
  output logic                   segActive,
  output logic      [3:0]        segNum,
  output logic                   endActive,
  output logic                   rampStop,
  output logic      [7:0]        digOut,
  output logic                   running
);
  // ==========================================================
  // declarations
  state_type            state, next_state;
  logic [SEQ_W-1:0]     curSeq, next_curSeq;
  logic [STEP_W-1:0]    curStep, next_curStep;
  logic [CYC_W-1:0]     cycLeft, next_cycLeft;
  logic                 next_segActive, next_endActive, next_rampStop, next_running;
  logic [3:0]           next_segNum;
  logic [7:0]           next_digOut;
  logic [DELAY_W-1:0]   endCount, next_endCount;
  logic                 endFired, next_endFired;
  logic [CYC_W-1:0]     cycCount [SEQ_COUNT];
  logic [CYC_W-1:0]     next_cycCount [SEQ_COUNT];
  logic [1:0]           endMode, next_endMode;
  logic                 endOutEn, next_endOutEn;
  logic [7:0]           endLevels, next_endLevels;
  logic [DELAY_W-1:0]   endDelay, next_endDelay;
  logic                 next_pready, next_pslverr;
  logic [31:0]          next_prdata;
  logic [7:0]           stepData, tableRdData;
  logic signed [7:0]    stepVal;
  logic [7:0]           callMag;
  logic [SEQ_W-1:0]     callSeq;
  logic                 isSeg, isCall;
  logic                 push, pop;
  logic [FRAME_W-1:0]   topFrame;
  logic [DEPTH_W-1:0]   depth;
  logic                 accessEnd, inTable, inCycle, lockedAddr, unmapped, refuse;
  logic                 wrOk, startReq, abortReq;

  // ==========================================================
  // apb decode
  assign accessEnd  = psel && penable && pready;
  assign inTable    = paddr <= STEP_TABLE_LAST;
  assign inCycle    = paddr >= CYCLE_BASE && paddr <= CYCLE_LAST;
  assign lockedAddr = inTable || inCycle || paddr == END_MODE_ADDR
                      || paddr == END_LEVELS_ADDR || paddr == END_DELAY_ADDR;
  assign unmapped   = paddr[1:0] != 2'h0 || paddr > STATUS_ADDR;
  assign refuse     = unmapped || (pwrite && lockedAddr && state != IDLE_S);
  assign wrOk       = accessEnd && pwrite && !refuse;
  assign startReq   = wrOk && paddr == CTRL_ADDR && pwdata[CTRL_START_BIT];
  assign abortReq   = wrOk && paddr == CTRL_ADDR && pwdata[CTRL_ABORT_BIT];

  always_comb begin
    next_pready  = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (next_pready) begin
      next_pslverr = refuse;
      if (!pwrite && !unmapped) begin
        if (inTable) begin
          next_prdata = {24'h00_0000, tableRdData};
        end else if (inCycle) begin
          next_prdata = {24'h00_0000, cycCount[paddr[4:2]]};
        end else if (paddr == END_MODE_ADDR) begin
          next_prdata = {27'h000_0000, endOutEn, 2'h0, endMode};
        end else if (paddr == END_LEVELS_ADDR) begin
          next_prdata = {24'h00_0000, endLevels};
        end else if (paddr == END_DELAY_ADDR) begin
          next_prdata = {16'h0000, endDelay};
        end else if (paddr == STATUS_ADDR) begin
          next_prdata[ST_RUN_BIT]                  = running;
          next_prdata[ST_END_BIT]                  = endActive;
          next_prdata[ST_RAMP_BIT]                 = rampStop;
          next_prdata[ST_SEQ_LSB +: SEQ_W]         = curSeq;
          next_prdata[ST_STEP_LSB +: STEP_W]       = curStep;
          next_prdata[ST_CYC_LSB +: CYC_W]         = cycLeft;
          next_prdata[ST_DEPTH_LSB +: DEPTH_W]     = depth;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ==========================================================
  // configuration registers
  always_comb begin
    next_endMode   = endMode;
    next_endOutEn  = endOutEn;
    next_endLevels = endLevels;
    next_endDelay  = endDelay;
    for (int i = 0; i < SEQ_COUNT; i++) begin
      next_cycCount[i] = cycCount[i];
    end
    if (wrOk && inCycle) begin
      next_cycCount[paddr[4:2]] = pwdata[7:0];
    end
    if (wrOk && paddr == END_MODE_ADDR) begin
      next_endMode  = pwdata[1:0];
      next_endOutEn = pwdata[END_OUT_EN_BIT];
    end
    if (wrOk && paddr == END_LEVELS_ADDR) begin
      next_endLevels = pwdata[7:0];
    end
    if (wrOk && paddr == END_DELAY_ADDR) begin
      next_endDelay = pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      endMode   <= END_KEEP_RUNNING;
      endOutEn  <= 1'b0;
      endLevels <= LEVELS_RESET;
      endDelay  <= DELAY_RESET;
      for (int i = 0; i < SEQ_COUNT; i++) begin
        cycCount[i] <= CYCLE_RESET;
      end
    end else begin
      endMode   <= next_endMode;
      endOutEn  <= next_endOutEn;
      endLevels <= next_endLevels;
      endDelay  <= next_endDelay;
      for (int i = 0; i < SEQ_COUNT; i++) begin
        cycCount[i] <= next_cycCount[i];
      end
    end
  end

  // ==========================================================
  // step table and call stack
  // eight tables of
  step_memory u_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (wrOk && inTable),
    .wrAddr  (paddr[8:2]),
    .wrData  (pwdata[7:0]),
    .rdAddrA ({curSeq, curStep}),
    .rdDataA (stepData),
    .rdAddrB (paddr[8:2]),
    .rdDataB (tableRdData)
  );

  call_stack u_stack (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .push      (push),
    .pop       (pop),
    .pushFrame ({curSeq, curStep, cycLeft}),
    .topFrame  (topFrame),
    .depth     (depth)
  );

  // ==========================================================
  // step decode
  assign stepVal = stepData;
  assign callMag = 8'(-stepVal);
  assign callSeq = 3'(callMag - 8'h01);
  assign isSeg   = stepVal >= SEG_MIN && stepVal <= SEG_MAX;
  assign isCall  = stepVal >= CALL_MIN && stepVal <= CALL_MAX && callSeq > curSeq;

  // ==========================================================
  // sequencer
  always_comb begin
    next_state     = state;
    next_curSeq    = curSeq;
    next_curStep   = curStep;
    next_cycLeft   = cycLeft;
    next_segActive = segActive;
    next_segNum    = segNum;
    next_endActive = endActive;
    next_rampStop  = rampStop;
    next_digOut    = digOut;
    next_endCount  = endCount;
    next_endFired  = endFired;
    push           = 1'b0;
    pop            = 1'b0;
    unique case (state)
      IDLE_S: begin
        if (startReq) begin
          next_curSeq   = '0;
          next_curStep  = '0;
          next_cycLeft  = cycCount[0] == 8'h00 ? 8'h01 : cycCount[0];
          next_endActive = 1'b0;
          next_rampStop  = 1'b0;
          next_state    = FETCH_S;
        end
      end
      FETCH_S: next_state = DECODE_S;
      DECODE_S: begin
        if (isSeg) begin
          next_segActive = 1'b1;
          next_segNum    = stepVal[3:0];
          next_state     = SEGMENT_S;
        end else if (isCall && depth < 4'(SEQ_COUNT)) begin
          push         = 1'b1;
          next_curSeq  = callSeq;
          next_curStep = '0;
          next_cycLeft = cycCount[callSeq] == 8'h00 ? 8'h01 : cycCount[callSeq];
          next_state   = FETCH_S;
        end else begin
          next_state = ADVANCE_S;
        end
      end
      SEGMENT_S: begin
        if (segDone) begin
          next_segActive = 1'b0;
          next_state     = ADVANCE_S;
        end
      end
      ADVANCE_S: begin
        if (curStep != 4'(STEP_COUNT - 1)) begin
          next_curStep = curStep + 4'h1;
          next_state   = FETCH_S;
        end else if (cycLeft > 8'h01) begin
          next_cycLeft = cycLeft - 8'h01;
          next_curStep = '0;
          next_state   = FETCH_S;
        end else if (depth != '0) begin
          pop          = 1'b1;
          next_curSeq  = topFrame[FRAME_W-1 -: SEQ_W];
          next_curStep = topFrame[CYC_W +: STEP_W];
          next_cycLeft = topFrame[CYC_W-1:0];
          next_state   = ADVANCE_S;
        end else begin
          next_endActive = endMode == END_KEEP_RUNNING;
          next_rampStop  = endMode != END_KEEP_RUNNING;
          next_endCount  = '0;
          next_endFired  = 1'b0;
          next_state     = END_S;
        end
      end
      END_S: begin
        if (endCount != endDelay) begin
          next_endCount = endCount + 16'h0001;
        end else if (!endFired) begin
          next_endFired = 1'b1;
          if (endOutEn) begin
            next_digOut = endLevels;
          end
          if (endMode == END_STOP_ABORT) begin
            next_state = IDLE_S;
          end
        end
      end
    endcase
    if (abortReq) begin
      next_state     = IDLE_S;
      next_segActive = 1'b0;
      next_endActive = 1'b0;
      next_rampStop  = 1'b0;
    end
    next_running = next_state != IDLE_S;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state     <= IDLE_S;
      curSeq    <= '0;
      curStep   <= '0;
      cycLeft   <= '0;
      segActive <= 1'b0;
      segNum    <= 4'h0;
      endActive <= 1'b0;
      rampStop  <= 1'b0;
      digOut    <= 8'h00;
      endCount  <= '0;
      endFired  <= 1'b0;
      running   <= 1'b0;
    end else begin
      state     <= next_state;
      curSeq    <= next_curSeq;
      curStep   <= next_curStep;
      cycLeft   <= next_cycLeft;
      segActive <= next_segActive;
      segNum    <= next_segNum;
      endActive <= next_endActive;
      rampStop  <= next_rampStop;
      digOut    <= next_digOut;
      endCount  <= next_endCount;
      endFired  <= next_endFired;
      running   <= next_running;
    end
  end

  // ==========================================================
  // assertions
  property p_lock;
    @(posedge clk_sys) disable iff (!resetn)
    (accessEnd && pwrite && inTable && running) |-> pslverr;
  endproperty
  a_lock: assert property (p_lock) else $error("config write accepted while running");

  property p_start;
    @(posedge clk_sys) disable iff (!resetn)
    (state == IDLE_S && startReq && !abortReq) |=> (state == FETCH_S && curSeq == '0 && curStep == '0);
  endproperty
  a_start: assert property (p_start) else $error("start did not begin main sequence");

  property p_segment;
    @(posedge clk_sys) disable iff (!resetn)
    (state == DECODE_S && isSeg && !abortReq) |=> (segActive && segNum == 4'($past(stepData)));
  endproperty
  a_segment: assert property (p_segment) else $error("segment not issued from step");

  property p_skip;
    @(posedge clk_sys) disable iff (!resetn)
    (state == DECODE_S && stepVal == 8'sh00 && !abortReq) |=> (state == ADVANCE_S && !segActive);
  endproperty
  a_skip: assert property (p_skip) else $error("zero step not skipped");

  property p_ascend;
    @(posedge clk_sys) disable iff (!resetn)
    push |=> (curSeq > topFrame[FRAME_W-1 -: SEQ_W]);
  endproperty
  a_ascend: assert property (p_ascend) else $error("call to non-higher sequence");

  property p_resume;
    @(posedge clk_sys) disable iff (!resetn)
    (pop && !abortReq) |=> (state == ADVANCE_S
                            && {curSeq, curStep, cycLeft} == $past(topFrame));
  endproperty
  a_resume: assert property (p_resume) else $error("caller not resumed at next step");

  property p_endhold;
    @(posedge clk_sys) disable iff (!resetn)
    (endActive && !abortReq) |=> (endActive && !segActive && !rampStop);
  endproperty
  a_endhold: assert property (p_endhold) else $error("end setpoint dropped");

  property p_levels;
    @(posedge clk_sys) disable iff (!resetn)
    (digOut != $past(digOut)) |-> ($past(state) == END_S && $past(endCount) == $past(endDelay));
  endproperty
  a_levels: assert property (p_levels) else $error("outputs changed before end delay");

  property p_ramp;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(rampStop) |-> (endMode != END_KEEP_RUNNING && !endActive && depth == '0);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp down in keep-running mode");
endmodule

// File: core/seq_pkg.sv
/*
 * constants, register map and state type of the nested step sequencer.
 * assumes a single 10 MHz system clock and a 32-bit APB register bus.
 */
package seq_pkg;
  // ==========================================================
  // geometry
  localparam int SEQ_COUNT   = 8;
  localparam int STEP_COUNT  = 16;
  localparam int SEQ_W       = 3;
  localparam int STEP_W      = 4;
  localparam int TABLE_AW    = 7;
  localparam int CYC_W       = 8;
  localparam int DEPTH_W     = 4;
  localparam int FRAME_W     = SEQ_W + STEP_W + CYC_W;
  localparam int ADDR_W      = 12;
  localparam int DELAY_W     = 16;

  // ==========================================================
  // register byte addresses
  localparam logic [11:0] STEP_TABLE_BASE = 12'h000;
  localparam logic [11:0] STEP_TABLE_LAST = 12'h1fc;
  localparam logic [11:0] CYCLE_BASE      = 12'h200;
  localparam logic [11:0] CYCLE_LAST      = 12'h21c;
  localparam logic [11:0] CTRL_ADDR       = 12'h220;
  localparam logic [11:0] END_MODE_ADDR   = 12'h224;
  localparam logic [11:0] END_LEVELS_ADDR = 12'h228;
  localparam logic [11:0] END_DELAY_ADDR  = 12'h22c;
  localparam logic [11:0] STATUS_ADDR     = 12'h230;

  // ==========================================================
  // field positions
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_ABORT_BIT  = 1;
  localparam int END_OUT_EN_BIT  = 4;
  localparam int ST_RUN_BIT      = 0;
  localparam int ST_END_BIT      = 1;
  localparam int ST_RAMP_BIT     = 2;
  localparam int ST_SEQ_LSB      = 4;
  localparam int ST_STEP_LSB     = 8;
  localparam int ST_CYC_LSB      = 12;
  localparam int ST_DEPTH_LSB    = 20;

  // ==========================================================
  // end of sequence modes and reset values
  localparam logic [1:0] END_KEEP_RUNNING = 2'h0;
  localparam logic [1:0] END_STOP         = 2'h1;
  localparam logic [1:0] END_STOP_ABORT   = 2'h2;
  localparam logic [7:0] CYCLE_RESET      = 8'h01;
  localparam logic [7:0] STEP_RESET       = 8'h00;
  localparam logic [7:0] LEVELS_RESET     = 8'h00;
  localparam logic [15:0] DELAY_RESET     = 16'h0000;
  localparam logic signed [7:0] SEG_MIN   = 8'sh01;
  localparam logic signed [7:0] SEG_MAX   = 8'sh08;
  localparam logic signed [7:0] CALL_MIN  = -8'sh08;
  localparam logic signed [7:0] CALL_MAX  = -8'sh02;

  typedef enum logic [2:0] {
    IDLE_S, FETCH_S, DECODE_S, SEGMENT_S, ADVANCE_S, END_S
  } state_type;
endpackage

// File: core/step_memory.sv
/*
 * step table memory: one write port, two registered read ports.
 * assumes writes come from the register bus, reads from sequencer and bus.
 */
`timescale 1ns/1ps
module step_memory
  import seq_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // write port
  input  wire logic                wrEn,
  input  wire logic [TABLE_AW-1:0] wrAddr,
  input  wire logic [7:0]          wrData,
  // read ports
  input  wire logic [TABLE_AW-1:0] rdAddrA,
  output logic      [7:0]          rdDataA,
  input  wire logic [TABLE_AW-1:0] rdAddrB,
  output logic      [7:0]          rdDataB
);
  // ==========================================================
  // storage
  logic [7:0] mem [SEQ_COUNT*STEP_COUNT];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SEQ_COUNT*STEP_COUNT; i++) begin
        mem[i] <= STEP_RESET;
      end
      rdDataA <= STEP_RESET;
      rdDataB <= STEP_RESET;
    end else begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
    end
  end
endmodule

// File: core/call_stack.sv
/*
 * return stack of caller frames {sequence, step, cycles left}.
 * assumes the caller never pushes when full nor pops when empty.
 */
`timescale 1ns/1ps
module call_stack
  import seq_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // control
  input  wire logic               push,
  input  wire logic               pop,
  input  wire logic [FRAME_W-1:0] pushFrame,
  // state
  output logic      [FRAME_W-1:0] topFrame,
  output logic      [DEPTH_W-1:0] depth
);
  // ==========================================================
  // top kept in a register, the rest below it
  logic [FRAME_W-1:0] below [SEQ_COUNT];
  logic [FRAME_W-1:0] next_topFrame;
  logic [DEPTH_W-1:0] next_depth;

  always_comb begin
    next_topFrame = topFrame;
    next_depth    = depth;
    if (push) begin
      next_topFrame = pushFrame;
      next_depth    = depth + 4'h1;
    end else if (pop) begin
      next_topFrame = below[3'(depth - 4'h1)];
      next_depth    = depth - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      topFrame <= '0;
      depth    <= '0;
    end else begin
      topFrame <= next_topFrame;
      depth    <= next_depth;
      if (push) begin
        below[3'(depth)] <= topFrame;
      end
    end
  end
endmodule

// File: bench/motor_model.sv
/*
 * motor control stand-in: answers each segment with one segDone pulse.
 * assumes segActive stays high until the edge after segDone.
 */
`timescale 1ns/1ps
module motor_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // segment handshake
  input  wire logic       segActive,
  input  wire logic [3:0] stallLen,
  output logic            segDone
);
  logic [3:0] waitCnt;
  logic       doneSent;

  // =========================================
  // one pulse per segment after a stall
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitCnt  <= 4'h0;
      doneSent <= 1'b0;
      segDone  <= 1'b0;
    end else begin
      segDone <= 1'b0;
      if (!segActive) begin
        waitCnt  <= 4'h0;
        doneSent <= 1'b0;
      end else if (!doneSent) begin
        if (waitCnt >= stallLen) begin
          segDone  <= 1'b1;
          doneSent <= 1'b1;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

// File: bench/nested_step_sequencer_test.sv
/*
 * self-checking bench of the nested step sequencer over apb.
 * assumes motor_model as the far side and seq_pkg compiled first.
 */
`timescale 1ns/1ps
module nested_step_sequencer_test;
  import seq_pkg::*;
  logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, lv;
  logic        pready, pslverr, err, segDone, segActive, endActive, rampStop, running;
  logic        lastAct = 0;
  logic [3:0]  segNum, stall = 0;
  logic [7:0]  digOut;
  int          fail_count = 0, n_checks = 0, seed, tbl[1:8][16], cyc[1:8];
  logic [31:0] want[$], got[$];

  nested_step_sequencer i_dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .segDone, .segActive, .segNum, .endActive,
    .rampStop, .digOut, .running);
  motor_model i_motor (.clk_sys, .resetn, .segActive, .stallLen(stall), .segDone);

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (segActive && !lastAct) got.push_back({28'h0, segNum});
    lastAct <= segActive;
  end

  // =========================================
  // reporting
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task hang();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop();
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask

  // =========================================
  // apb master
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // =========================================
  // expected segment order by in-place expansion
  function automatic void expand(input int s);
    for (int c = 0; c < cyc[s]; c++)
      for (int k = 0; k < 16; k++)
        if (tbl[s][k] >= 1 && tbl[s][k] <= 8) want.push_back(tbl[s][k]);
        else if (tbl[s][k] <= -2 && tbl[s][k] >= -8 && -tbl[s][k] > s) expand(-tbl[s][k]);
  endfunction

  task run(input logic [31:0] mode);
    int n;
    want.delete();
    got.delete();
    for (int s = 1; s <= 8; s++) begin
      apb(1, CYCLE_BASE + 12'(4 * (s - 1)), cyc[s]);
      for (int k = 0; k < 16; k++) apb(1, 12'(4 * (16 * (s - 1) + k)), tbl[s][k] & 32'hff);
    end
    apb(1, END_MODE_ADDR, mode);
    apb(1, END_LEVELS_ADDR, lv);
    apb(1, END_DELAY_ADDR, 32'h5);
    expand(1);
    apb(1, CTRL_ADDR, 32'h1);
    apb(1, STEP_TABLE_BASE, 32'h3);
    check(err, 1, "write taken while running");
    apb(0, STEP_TABLE_BASE, 0);
    check(rd, tbl[1][0] & 32'hff, "step changed while running");
    for (n = 0; n < 60000 && !(endActive || rampStop); n++) @(posedge clk_sys);
    if (n == 60000) hang();
    check(got.size(), want.size(), "segment count");
    foreach (want[i]) check(got[i], want[i], "segment order");
  endtask

  // =========================================
  // main sequence
  initial begin
    seed = 32'h0833;
    repeat (16) @(posedge clk_sys);
    resetn <= 1;
    apb(0, CYCLE_BASE, 0);
    check(rd, {24'h0, CYCLE_RESET}, "cycle count reset");
    apb(0, STATUS_ADDR + 12'h4, 0);
    check(err, 1, "unmapped read accepted");
    foreach (tbl[s, k]) tbl[s][k] = 0;
    foreach (cyc[s]) cyc[s] = 1;
    tbl[1] = '{0: -2, 1: -3, 2: 7, 3: 8, 4: -1, 5: 9, default: 0};
    tbl[2] = '{0: 1, 1: 2, 2: 3, 3: -2, default: 0};
    tbl[3] = '{0: 4, 1: -6, 2: 4, 3: 3, 4: 1, default: 0};
    tbl[6] = '{0: 5, 1: 7, 2: 8, 15: 2, default: 0};
    cyc[1] = 4;
    lv = 0;
    stall <= 1;
    run({30'h0, END_KEEP_RUNNING});
    repeat (20) @(posedge clk_sys);
    check(endActive, 1, "end setpoint dropped");
    check(segActive, 0, "segment after end");
    apb(1, CTRL_ADDR, 32'h2);
    repeat (2) @(posedge clk_sys);
    check(running, 0, "abort ignored");
    // calls only from sequences one and two keep the expansion short
    foreach (tbl[s, k])
      tbl[s][k] = (k >= (s == 1 ? 6 : 3)) ? 0 :
                  (s <= 2) ? $random(seed) % 10 : {$random(seed)} % 10;
    tbl[1][0] = 1 + {$random(seed)} % 8;
    cyc[1] = 2;
    cyc[2] = 3;
    stall <= 4'($random(seed));
    lv = $random(seed) & 32'hff;
    run(32'h12);
    check(rampStop, 1, "no ramp down");
    for (int n = 0; n < 50 && running; n++) @(posedge clk_sys);
    check(running, 0, "stop and abort stayed busy");
    check(digOut, lv[7:0], "end output levels");
    cyc[2] = 1;
    run({30'h0, END_STOP});
    repeat (20) @(posedge clk_sys);
    check(running, 1, "stop mode left end state");
    apb(0, STATUS_ADDR, 0);
    check(rd[2:0], 3'h5, "stop mode status");
    report_and_stop();
  end
endmodule
